// ===== bench/rsw_wd_properties.sv
`timescale 1ns/1ps
module rsw_wd_props
  import rsw_pkg::*;
#(
  parameter int POR_DELAY = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Inputs
  input wire logic reset_pin,
  input wire logic long_delay_option,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  // Outputs
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sys_reset,
  input wire logic boot_from_isp,
  input wire logic [2:0] flash_wait_select
);
  localparam int HOLD_LO = POR_DELAY - 2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_por;
    $rose(resetn) && !long_delay_option && !reset_pin;
  endsequence
  sequence s_fp_wr;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFS_FLASH_PROGRAM_CONTROL;
  endsequence
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_por_hold: assert property (s_por |-> ##HOLD_LO sys_reset ##[1:8] !sys_reset)
    else $error("power-on hold wrong");
  a_pin_follow: assert property (reset_pin |=> sys_reset)
    else $error("pin reset not followed");
  a_sw_reset: assert property (s_fp_wr ##0 avs_writedata[5] |-> ##[1:3] sys_reset)
    else $error("software reset missing");
  a_flash_outs: assert property (s_fp_wr ##0 !avs_writedata[5] |=>
    flash_wait_select == $past(avs_writedata[2:0]) && boot_from_isp == $past(avs_writedata[6]))
    else $error("flash control outputs wrong");
  a_boot_kept: assert property (sys_reset && !reset_pin && !$past(reset_pin) && !avs_write
    |=> $stable(boot_from_isp))
    else $error("boot select lost in reset");
endmodule
bind rsw_reset_watchdog rsw_wd_props #(.POR_DELAY(POR_DELAY)) rsw_wd_props_i (
  .clk_sys(clk_sys), .resetn(resetn), .reset_pin(reset_pin),
  .long_delay_option(long_delay_option), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_reset(sys_reset),
  .boot_from_isp(boot_from_isp), .flash_wait_select(flash_wait_select));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rsw_pkg::*;
  localparam int POR = 16;
  localparam int LNG = 20;
  logic clk_sys = 0, resetn = 0, pin = 0, lopt = 0, rd = 0, wr = 0;
  logic idle = 0, c6 = 0;
  logic wq, sr, boot, fen;
  logic [9:0] ad = 10'h000;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0, rq, q;
  logic [2:0] fws;
  logic [7:0] pco;
  int failures = 0, check_count = 0, cyc = 0, n;
  // Idle and 6-clock mode only shape overflow timing, too long to reach here
  rsw_reset_watchdog #(.LONG_DELAY(LNG), .POR_DELAY(POR)) rsw_reset_watchdog_i (
    .clk_sys(clk_sys), .resetn(resetn), .reset_pin(pin), .core_idle(idle),
    .core_clk6_mode(c6), .long_delay_option(lopt), .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rq),
    .avs_waitrequest(wq), .sys_reset(sr), .boot_from_isp(boot), .flash_access_enable(fen),
    .flash_wait_select(fws), .power_control_out(pco));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    ad <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk_sys);
    while (wq !== 1'b0) @(posedge clk_sys);
    q = rq;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic held();
    n = 0;
    while (sr !== 1'b0) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_por();
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    held();
    chk(n >= POR && n <= POR + 3, 1);
    rd_chk(OFS_POWER_CONTROL, 8'h10);
    rd_chk(OFS_FLASH_PROGRAM_CONTROL, 8'h00);
  endtask
  task automatic t_wd();
    idle <= 1'b1;
    c6 <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_WATCHDOG_CONTROL, 8'h38 | i[7:0]);
      rd_chk(OFS_WATCHDOG_CONTROL, 8'h28 | i[7:0]);
      bus(1'b1, OFS_WATCHDOG_CONTROL, 8'h38 | i[7:0]);
    end
    idle <= 1'b0;
    c6 <= 1'b0;
    bus(1'b1, OFS_WATCHDOG_CONTROL, 8'h00);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'h00);
  endtask
  task automatic t_pin();
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(sr, 1);
    pin <= 1'b0;
    held();
    rd_chk(OFS_POWER_CONTROL, 8'h10);
    bus(1'b1, OFS_POWER_CONTROL, 8'h1c);
    rd_chk(OFS_POWER_CONTROL, 8'h1c);
    bus(1'b1, OFS_POWER_CONTROL, 8'h0c);
    rd_chk(OFS_POWER_CONTROL, 8'h0c);
  endtask
  task automatic t_sw();
    bus(1'b1, OFS_WATCHDOG_CONTROL, 8'h20);
    bus(1'b1, OFS_FLASH_PROGRAM_CONTROL, 8'h85);
    chk({boot, fen, fws}, 5'h0d);
    bus(1'b1, OFS_FLASH_PROGRAM_CONTROL, 8'h65);
    while (sr !== 1'b1) @(posedge clk_sys);
    held();
    chk(boot, 1);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'h00);
    bus(1'b0, OFS_FLASH_PROGRAM_CONTROL, 8'h00);
    chk(q & 32'h60, 32'h40);
    chk(pco[4], 0);
  endtask
  task automatic t_refuse();
    be <= 4'h0;
    bus(1'b1, OFS_WATCHDOG_CONTROL, 8'h27);
    be <= 4'hf;
    rd_chk(OFS_WATCHDOG_CONTROL, 8'h00);
    bus(1'b1, 10'h3a0, 8'hff);
    rd_chk(10'h3a0, 8'h00);
  endtask
  task automatic t_long();
    lopt <= 1'b1;
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    held();
    chk(n >= POR + LNG && n <= POR + LNG + 3, 1);
    rd_chk(OFS_POWER_CONTROL, 8'h10);
    rd_chk(OFS_FLASH_PROGRAM_CONTROL, 8'h00);
  endtask
  initial begin
    t_por();
    t_wd();
    t_pin();
    t_sw();
    t_refuse();
    t_long();
    final_report();
  end
endmodule

// ===== common/rsw_pkg.sv
package rsw_pkg;
  // Avalon word byte addresses (SFR address times four)
  localparam logic [9:0] OFS_WATCHDOG_CONTROL = 10'h384;
  localparam logic [9:0] OFS_POWER_CONTROL = 10'h21c;
  localparam logic [9:0] OFS_FLASH_PROGRAM_CONTROL = 10'h394;
  localparam logic [9:0] OFS_RESET_STATUS = 10'h3f0;
  localparam logic [7:0] SFR_WATCHDOG_CONTROL = 8'he1;
  localparam logic [7:0] SFR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SFR_FLASH_PROGRAM_CONTROL = 8'he5;
  localparam logic [7:0] SFR_RESET_STATUS = 8'hfc;
  // Watchdog control fields
  localparam int WD_RUN_BIT = 5;
  localparam int WD_RESTART_BIT = 4;
  localparam int WD_IDLE_RUN_BIT = 3;
  // Power control fields
  localparam int PC_POWER_ON_FLAG_BIT = 4;
  localparam logic [7:0] PC_WRITE_MASK = 8'hdf;
  // Flash program control fields
  localparam int FP_ACCESS_EN_BIT = 7;
  localparam int FP_BOOT_SEL_BIT = 6;
  localparam int FP_SW_RESET_BIT = 5;
  localparam logic [7:0] FP_WRITE_MASK = 8'he7;
  // Reset values
  localparam logic [7:0] WD_CTRL_RESET = 8'h00;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] FP_RESET = 8'h00;
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int POR_DELAY_CLOCKS = 32768;
  localparam int LONG_DELAY_MS = 400;
  localparam int LONG_DELAY_CYCLES = (CLK_HZ / 1000) * LONG_DELAY_MS;
  localparam int N_CLK12 = 12;
  localparam int N_CLK6 = 6;
  localparam int PRESCALE_W = 8;
  localparam int COUNT_W = 15;

  typedef enum logic [1:0] {ST_HOLD, ST_LONG, ST_RUN} rsw_phase_e;

  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } rsw_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic readdatavalid_unused;
  } rsw_bus_rsp_s;
endpackage

// ===== src/rsw_reset_watchdog.sv
`timescale 1ns/1ps
module rsw_reset_watchdog
  import rsw_pkg::*;
#(
  parameter int LONG_DELAY = LONG_DELAY_CYCLES,
  parameter int POR_DELAY = POR_DELAY_CLOCKS
) (
  // Clock and reset; resetn is the power-on detector output
  input wire logic clk_sys,
  input wire logic resetn,
  // Reset pin level, already synchronous; high means reset
  input wire logic reset_pin,
  // Core status and option
  input wire logic core_idle,
  input wire logic core_clk6_mode,
  input wire logic long_delay_option,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System outputs
  output logic sys_reset,
  output logic boot_from_isp,
  output logic flash_access_enable,
  output logic [2:0] flash_wait_select,
  output logic [7:0] power_control_out
);

  typedef struct packed {
    rsw_phase_e phase;
    logic [31:0] hold_count;
    logic [7:0] watchdog_control;
    logic [7:0] power_control;
    logic [7:0] flash_program_control;
    logic [PRESCALE_W-1:0] prescale_count;
    logic [COUNT_W-1:0] wd_count;
    logic [3:0] mcycle_count;
    logic sw_reset_pending;
    logic wd_reset_pending;
    logic [3:0] last_cause;
    logic [31:0] readdata;
    logic waitrequest;
    logic sys_reset;
  } rsw_state_s;

  rsw_state_s state;
  rsw_state_s next_state;

  logic [7:0] wd_fields;
  logic [8:0] prescale_div;
  logic [3:0] n_sel;
  logic wd_tick;
  logic wd_overflow;
  logic wd_counting;
  logic access;
  logic wr_low;
  logic [7:0] wbyte;

  always_comb begin
    wd_fields = state.watchdog_control;
    prescale_div = 9'h002 << wd_fields[2:0];
    n_sel = core_clk6_mode ? 4'(N_CLK6) : 4'(N_CLK12);
    access = (avs_read || avs_write) && state.waitrequest;
    // Write lands at the answer edge, where the master sees waitrequest low
    wr_low = avs_write && !state.waitrequest && avs_byteenable[0];
    wbyte = avs_writedata[7:0];
    // Run bit plus idle gating decide whether time advances
    wd_counting = wd_fields[WD_RUN_BIT] && (!core_idle || wd_fields[WD_IDLE_RUN_BIT]);
    // Prescaler advances once per machine cycle (N clocks), so interval is N*pre*32768
    wd_tick = wd_counting && (state.mcycle_count == n_sel - 4'h1)
      && ({1'b0, state.prescale_count} == prescale_div - 9'h001);
    wd_overflow = wd_tick && (state.wd_count == {COUNT_W{1'b1}});
  end

  always_comb begin
    next_state = state;
    next_state.waitrequest = 1'b1;
    // One wait state: waitrequest drops in the cycle after the request is seen
    if (access) begin
      next_state.waitrequest = 1'b0;
      next_state.readdata = 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          OFS_WATCHDOG_CONTROL: next_state.readdata = {24'h000000, state.watchdog_control};
          OFS_POWER_CONTROL: next_state.readdata = {24'h000000, state.power_control};
          OFS_FLASH_PROGRAM_CONTROL:
            next_state.readdata = {24'h000000, state.flash_program_control};
          OFS_RESET_STATUS: next_state.readdata = {28'h0000000, state.last_cause};
          default: next_state.readdata = 32'h0000_0000;
        endcase
      end
    end
    // Machine cycle and watchdog timebase
    if (wd_counting) begin
      next_state.mcycle_count = (state.mcycle_count == n_sel - 4'h1) ? 4'h0
        : state.mcycle_count + 4'h1;
      if (state.mcycle_count == n_sel - 4'h1) begin
        if ({1'b0, state.prescale_count} == prescale_div - 9'h001) begin
          next_state.prescale_count = '0;
          next_state.wd_count = state.wd_count + 15'h0001;
        end else begin
          next_state.prescale_count = state.prescale_count + 8'h01;
        end
      end
    end
    if (wd_overflow) begin
      next_state.wd_reset_pending = 1'b1;
    end
    // Restart bit never stores; it zeroes the count
    next_state.watchdog_control[WD_RESTART_BIT] = 1'b0;
    if (wr_low && avs_address == OFS_WATCHDOG_CONTROL) begin
      next_state.watchdog_control = {2'b00, wbyte[5], 1'b0, wbyte[3:0]};
      if (wbyte[WD_RESTART_BIT]) begin
        next_state.wd_count = '0;
        next_state.prescale_count = '0;
        next_state.mcycle_count = '0;
      end
      if (!wbyte[WD_RUN_BIT]) begin
        next_state.wd_count = '0;
        next_state.prescale_count = '0;
      end
    end
    if (wr_low && avs_address == OFS_POWER_CONTROL) begin
      // Flag can only be cleared by writing zero, never set by software
      next_state.power_control = (wbyte & PC_WRITE_MASK & ~8'h10)
        | (wbyte & state.power_control & 8'h10);
    end
    if (wr_low && avs_address == OFS_FLASH_PROGRAM_CONTROL) begin
      next_state.flash_program_control = wbyte & FP_WRITE_MASK;
      if (wbyte[FP_SW_RESET_BIT]) begin
        next_state.sw_reset_pending = 1'b1;
      end
    end
    // Reset sequencing
    case (state.phase)
      ST_HOLD: begin
        next_state.sys_reset = 1'b1;
        if (state.hold_count >= 32'(POR_DELAY - 1)) begin
          next_state.hold_count = '0;
          next_state.phase = long_delay_option ? ST_LONG : ST_RUN;
          next_state.sys_reset = long_delay_option;
        end else begin
          next_state.hold_count = state.hold_count + 32'h1;
        end
      end
      ST_LONG: begin
        next_state.sys_reset = 1'b1;
        if (state.hold_count >= 32'(LONG_DELAY - 1)) begin
          next_state.hold_count = '0;
          next_state.phase = ST_RUN;
          next_state.sys_reset = 1'b0;
        end else begin
          next_state.hold_count = state.hold_count + 32'h1;
        end
      end
      ST_RUN: begin
        next_state.sys_reset = 1'b0;
        if (reset_pin || state.wd_reset_pending || state.sw_reset_pending) begin
          next_state.sys_reset = 1'b1;
          next_state.last_cause = {1'b0, state.sw_reset_pending, state.wd_reset_pending,
            reset_pin};
          next_state.phase = reset_pin ? ST_RUN : ST_HOLD;
          next_state.hold_count = '0;
          next_state.wd_reset_pending = 1'b0;
          next_state.sw_reset_pending = 1'b0;
          // Boot choice and power-on flag survive this reset
          next_state.watchdog_control = WD_CTRL_RESET;
          next_state.flash_program_control = (state.flash_program_control
            & (8'h01 << FP_BOOT_SEL_BIT));
          next_state.power_control = state.power_control & 8'h10;
          next_state.wd_count = '0;
          next_state.prescale_count = '0;
          next_state.mcycle_count = '0;
        end
      end
      default: begin
        next_state.phase = ST_HOLD;
        next_state.sys_reset = 1'b1;
      end
    endcase
    // Pin-driven reset stays asserted while the pin is high, without a long hold
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // Power-on detect: rest cleared, flag set, last cause set to 8, sys_reset and waitrequest high, hold counter restarts
      state <= '0;
      state.phase <= ST_HOLD;
      state.sys_reset <= 1'b1;
      state.power_control <= PC_RESET | 8'h10;
      state.watchdog_control <= WD_CTRL_RESET;
      state.flash_program_control <= FP_RESET;
      state.last_cause <= 4'h8;
      state.waitrequest <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata = state.readdata;
  assign avs_waitrequest = state.waitrequest;
  assign sys_reset = state.sys_reset;
  assign boot_from_isp = state.flash_program_control[FP_BOOT_SEL_BIT];
  assign flash_access_enable = state.flash_program_control[FP_ACCESS_EN_BIT];
  assign flash_wait_select = state.flash_program_control[2:0];
  assign power_control_out = state.power_control;

endmodule
